//--- hdl/ssr_receiver.sv
`timescale 1ns/10ps
`default_nettype none
module ssr_receiver
    import ssr_pkg::*;
#(
    parameter int UNIT_CYC_P = UNIT_CYC
) (
    input  wire logic              core_clk_i,
    input  wire logic              nrst_i,
    input  wire logic              line_i,
    input  wire logic signed [7:0] sample_ofs_i,
    input  wire logic              parity_even_i,
    input  wire logic              mono_colour_i,
    input  wire logic              feed_out_req_i,
    output ssr_rx_out_t            rx_o,
    output ssr_fn_out_t            fn_o,
    output logic                   at_rest_o,
    output logic                   fn_busy_o
);

    localparam int CW = $clog2(UNIT_CYC_P + 1);
    localparam int PHASE_STEP = UNIT_CYC_P / PHASE_STEPS;
    localparam int HALF_UNIT  = UNIT_CYC_P / 2;
    localparam logic [CW-1:0] UNIT_LAST = CW'(UNIT_CYC_P - 1);
    localparam logic [2:0] LAST_BIT = 3'(DATA_BITS - 1);

    function automatic logic is_control(input logic [7:0] c);
        is_control = (c[6:0] < GRAPHIC_MIN) || (c[6:0] == DEL_CODE);
    endfunction

    // Function cycle events fall on one divider tick each
    function automatic logic tick_is(input logic [FN_TW-1:0] t, input int n);
        tick_is = (t == FN_TW'(n - 1));
    endfunction

    // Selecting cycle state
    ssr_sel_state_t sel_q, sel_d;
    logic [CW-1:0]  sel_cnt_q, sel_cnt_d;
    logic [2:0]     bit_q, bit_d;
    logic [7:0]     code_q, code_d;
    logic           line_prev_q;

    // Function cycle state
    ssr_fn_state_t  fn_q, fn_d;
    logic [CW-1:0]  div_q;
    logic [FN_TW-1:0] fn_tick_q, fn_tick_d;
    logic           pend_q, pend_d;
    logic           pend_feed_q, pend_feed_d;
    logic [7:0]     pend_code_q, pend_code_d;
    logic [7:0]     fn_code_q, fn_code_d;
    logic           fn_feed_q, fn_feed_d;

    ssr_rx_out_t    rx_d;
    ssr_fn_out_t    fn_out_d;

    // Sampling point and unit boundaries
    logic signed [31:0] samp_int;
    logic [CW-1:0]      samp_pt;
    logic               at_sample;
    logic               unit_end;
    logic               start_edge;
    logic               last_bit;
    logic               sel_trip;
    logic [7:0]         code_next;

    // Offset steps move the sample point away from the unit centre
    assign samp_int   = HALF_UNIT + int'(sample_ofs_i) * PHASE_STEP;
    assign samp_pt    = CW'(samp_int);
    assign at_sample  = (sel_cnt_q == samp_pt);
    assign unit_end   = (sel_cnt_q == UNIT_LAST);
    assign start_edge = (line_prev_q == MARK) && (line_i == SPACE);
    assign last_bit   = (bit_q == LAST_BIT);
    assign sel_trip   = (sel_q == SEL_BITS) && at_sample && last_bit;
    assign code_next  = code_q | (8'(line_i) << bit_q);

    // Free-running drive ticks
    logic               div_tick;
    logic               fn_run;
    logic               fn_take;
    logic               fn_done;
    logic               print_now;
    logic               adv_now;
    logic               suppress;
    logic               char_pend;

    assign div_tick  = (div_q == UNIT_LAST);
    assign fn_run    = (fn_q == FN_RUN);
    assign fn_take   = (fn_q == FN_IDLE) && pend_q;
    assign fn_done   = fn_run && div_tick && tick_is(fn_tick_q, FN_LEN_TICKS);
    assign print_now = fn_run && div_tick && tick_is(fn_tick_q, FN_PRINT_TICK);
    assign adv_now   = fn_run && div_tick && tick_is(fn_tick_q, FN_ADV_TICK);
    // Feed-out tape is blank, so nothing is printed for it
    assign suppress  = fn_feed_q || (mono_colour_i && is_control(fn_code_q));
    // A queued character is never displaced by a feed request
    assign char_pend = pend_q && !pend_feed_q && !fn_take;

    always_comb begin
        sel_d     = sel_q;
        sel_cnt_d = unit_end ? '0 : sel_cnt_q + CW'(1);
        bit_d     = bit_q;
        code_d    = code_q;
        rx_d      = '0;
        rx_d.code = rx_o.code;
        unique case (sel_q)
            SEL_REST: begin
                sel_cnt_d = '0;
                if (start_edge) begin
                    sel_d     = SEL_START;
                    sel_cnt_d = CW'(1);
                    bit_d     = '0;
                    code_d    = '0;
                end
            end
            SEL_START: begin
                // False start: line back to marking at the sample point
                if (at_sample && line_i == MARK) begin
                    sel_d = SEL_REST;
                end else if (unit_end) begin
                    sel_d = SEL_BITS;
                end
            end
            SEL_BITS: begin
                if (at_sample) begin
                    code_d = code_next;
                end
                if (unit_end) begin
                    bit_d = bit_q + 3'd1;
                    if (last_bit) begin
                        sel_d = SEL_STOP;
                    end
                end
            end
            SEL_STOP: begin
                // Second stop unit is not waited for
                if (at_sample) begin
                    sel_d           = SEL_REST;
                    rx_d.valid      = 1'b1;
                    rx_d.code       = code_q;
                    rx_d.frame_err  = (line_i == SPACE);
                    rx_d.parity_err = parity_even_i && ^code_q;
                end
            end
        endcase
    end

    // Trip requests queue one behind a running function cycle
    always_comb begin
        pend_d      = pend_q && !fn_take;
        pend_feed_d = pend_feed_q;
        pend_code_d = pend_code_q;
        if (sel_trip) begin
            pend_d      = 1'b1;
            pend_feed_d = 1'b0;
            pend_code_d = code_next;
        end else if (feed_out_req_i && !char_pend) begin
            pend_d      = 1'b1;
            pend_feed_d = 1'b1;
            pend_code_d = BLANK_CODE;
        end
    end

    always_comb begin
        fn_d      = fn_q;
        fn_tick_d = fn_tick_q;
        fn_code_d = fn_code_q;
        fn_feed_d = fn_feed_q;
        fn_out_d  = '0;
        fn_out_d.holes = fn_o.holes;
        unique case (fn_q)
            FN_IDLE: begin
                if (pend_q) begin
                    fn_d      = FN_RUN;
                    fn_tick_d = '0;
                    fn_code_d = pend_code_q;
                    fn_feed_d = pend_feed_q;
                    fn_out_d.punch     = 1'b1;
                    fn_out_d.feed_hole = 1'b1;
                    fn_out_d.holes     = pend_code_q;
                end
            end
            FN_RUN: begin
                if (div_tick) begin
                    fn_tick_d = fn_tick_q + FN_TW'(1);
                end
                if (print_now && !suppress) begin
                    fn_out_d.print = 1'b1;
                    fn_out_d.red   = fn_code_q[5] ^ fn_code_q[6];
                end
                if (adv_now) begin
                    fn_out_d.advance = 1'b1;
                end
                if (fn_done) begin
                    fn_d = FN_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sel_q     <= SEL_REST;
            sel_cnt_q <= '0;
            bit_q     <= '0;
        end else begin
            sel_q     <= sel_d;
            sel_cnt_q <= sel_cnt_d;
            bit_q     <= bit_d;
        end
    end

    // Assembled code bits, cleared at each start unit
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            code_q <= '0;
        end else begin
            code_q <= code_d;
        end
    end

    // Line history resets to marking: a line held spacing from reset starts one frame
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            line_prev_q <= MARK;
        end else begin
            line_prev_q <= line_i;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_q <= '0;
        end else begin
            div_q <= div_tick ? '0 : div_q + CW'(1);
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fn_q      <= FN_IDLE;
            fn_tick_q <= '0;
            fn_code_q <= '0;
            fn_feed_q <= 1'b0;
        end else begin
            fn_q      <= fn_d;
            fn_tick_q <= fn_tick_d;
            fn_code_q <= fn_code_d;
            fn_feed_q <= fn_feed_d;
        end
    end

    // One-deep slot for the next function trip
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pend_q      <= 1'b0;
            pend_feed_q <= 1'b0;
            pend_code_q <= '0;
        end else begin
            pend_q      <= pend_d;
            pend_feed_q <= pend_feed_d;
            pend_code_q <= pend_code_d;
        end
    end

    // Top outputs come straight from flip-flops
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx_o <= '0;
            fn_o <= '0;
        end else begin
            rx_o <= rx_d;
            fn_o <= fn_out_d;
        end
    end

    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            at_rest_o <= 1'b1;
            fn_busy_o <= 1'b0;
        end else begin
            at_rest_o <= (sel_d == SEL_REST);
            fn_busy_o <= (fn_d == FN_RUN);
        end
    end

endmodule // ssr_receiver
`default_nettype wire

//--- hdl/ssr_pkg.sv
`default_nettype none
package ssr_pkg;
    // Clock and line timing
    localparam int CLK_PERIOD_NS = 25;
    // Unit interval, arbitrary 110 kbaud line rate
    localparam int UNIT_NS       = 9091;
    localparam int UNIT_CYC      = (UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Frame layout in units
    localparam int FRAME_UNITS = 11;
    localparam int START_UNITS = 1;
    localparam int DATA_BITS   = 8;
    localparam int STOP_UNITS  = 2;

    // Sampling phase resolution (steps per unit)
    localparam int PHASE_STEPS = 256;

    // Function cycle timing in divider ticks
    localparam int FN_PRINT_TICK = 4;
    localparam int FN_ADV_TICK   = 8;
    localparam int FN_LEN_TICKS  = 10;
    localparam int FN_TW         = 4;

    // Line levels
    localparam logic MARK  = 1'b1;
    localparam logic SPACE = 1'b0;

    // Code classes
    localparam logic [6:0] GRAPHIC_MIN = 7'h20;
    localparam logic [6:0] DEL_CODE    = 7'h7F;
    localparam logic [7:0] BLANK_CODE  = 8'h00;

    typedef enum logic [1:0] {SEL_REST, SEL_START, SEL_BITS, SEL_STOP} ssr_sel_state_t;
    typedef enum logic {FN_IDLE, FN_RUN} ssr_fn_state_t;

    typedef struct packed {
        logic       punch;
        logic       feed_hole;
        logic [7:0] holes;
        logic       print;
        logic       red;
        logic       advance;
    } ssr_fn_out_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] code;
        logic       frame_err;
        logic       parity_err;
    } ssr_rx_out_t;
endpackage
`default_nettype wire

//--- bench/ssr_line_model.sv
`timescale 1ns/10ps
`default_nettype none
module ssr_line_model #(
    parameter int U = 512
) (
    input  wire logic       core_clk_i,
    input  wire logic       go_i,
    input  wire logic [7:0] code_i,
    input  wire logic       bad_stop_i,
    output logic            line_o,
    output logic            busy_o
);
    logic [10:0] f_q;
    int          n_q = 11 * U;
    // Eleven equal units, start spacing, code LSB first, two stops
    always @(posedge core_clk_i) begin
        if (!busy_o && go_i) begin
            f_q <= {1'b1, !bad_stop_i, code_i, 1'b0};
            n_q <= 0;
        end else if (busy_o) begin
            n_q <= n_q + 1;
        end
    end
    assign busy_o = n_q < 11 * U;
    // Marking is current, idle line marks
    assign line_o = busy_o ? f_q[n_q / U] : 1'b1;
endmodule // ssr_line_model
`default_nettype wire

//--- bench/ssr_receiver_checker.sv
`timescale 1ns/10ps
`default_nettype none
module ssr_receiver_checker
    import ssr_pkg::*;
(
    input wire logic        core_clk_i,
    input wire logic        nrst_i,
    input wire logic        line_i,
    input wire logic        parity_even_i,
    input wire logic        mono_colour_i,
    input wire ssr_rx_out_t rx_o,
    input wire ssr_fn_out_t fn_o,
    input wire logic        at_rest_o,
    input wire logic        fn_busy_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    property p_idle;
        at_rest_o && line_i |=> at_rest_o;
    endproperty
    a_idle: assert property (p_idle) else $error("left rest on mark");
    property p_start;
        at_rest_o && !line_i && $past(line_i) |=> !at_rest_o;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");
    property p_stop;
        rx_o.valid |-> at_rest_o && rx_o.frame_err == !$past(line_i);
    endproperty
    a_stop: assert property (p_stop) else $error("bad stop handling");
    property p_par;
        rx_o.valid && parity_even_i |-> rx_o.parity_err == ^rx_o.code;
    endproperty
    a_par: assert property (p_par) else $error("parity flag wrong");
    property p_punch;
        $rose(fn_busy_o) |-> fn_o.punch && fn_o.feed_hole;
    endproperty
    a_punch: assert property (p_punch) else $error("no punch at start");
    property p_print;
        fn_o.print && mono_colour_i |->
            fn_o.holes[6:0] >= GRAPHIC_MIN && fn_o.holes[6:0] != DEL_CODE;
    endproperty
    a_print: assert property (p_print) else $error("control printed");
    property p_red;
        fn_o.print |-> fn_busy_o && fn_o.red == (fn_o.holes[5] ^ fn_o.holes[6]);
    endproperty
    a_red: assert property (p_red) else $error("print outside cycle");
    property p_adv;
        fn_o.advance |-> fn_busy_o ##1 !fn_o.advance;
    endproperty
    a_adv: assert property (p_adv) else $error("advance wrong");
endmodule // ssr_receiver_checker
bind ssr_receiver ssr_receiver_checker u_chk (
    .core_clk_i(core_clk_i), .nrst_i(nrst_i), .line_i(line_i), .parity_even_i(parity_even_i),
    .mono_colour_i(mono_colour_i), .rx_o(rx_o), .fn_o(fn_o), .at_rest_o(at_rest_o),
    .fn_busy_o(fn_busy_o)
);
`default_nettype wire

//--- bench/ssr_receiver_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ssr_receiver_tb import ssr_pkg::*; ;
    localparam int U = 512;
    logic              clk = 1'b0, nrst = 1'b0, go = 1'b0, bad = 1'b0, feed = 1'b0;
    logic              mono = 1'b0, par = 1'b0, glitch = 1'b0, rest, busy;
    logic signed [7:0] ofs = 8'sh00;
    logic [7:0]        code = 8'h00, holes;
    wire               line, mbusy;
    ssr_rx_out_t       rx;
    ssr_fn_out_t       fn;
    int                failures = 0, total_checks = 0, n_pr = 0, n_pu = 0, n_ad = 0;
    initial begin
        forever #12.5 clk = ~clk;
    end
    ssr_receiver #(.UNIT_CYC_P(U)) DUT (
        .core_clk_i(clk), .nrst_i(nrst), .line_i(line & !glitch), .sample_ofs_i(ofs),
        .parity_even_i(par), .mono_colour_i(mono), .feed_out_req_i(feed),
        .rx_o(rx), .fn_o(fn), .at_rest_o(rest), .fn_busy_o(busy));
    ssr_line_model #(.U(U)) u_far (.core_clk_i(clk), .go_i(go), .code_i(code),
        .bad_stop_i(bad), .line_o(line), .busy_o(mbusy));
    always @(posedge clk) begin
        if (fn.punch === 1'b1) begin
            n_pu++;
            holes <= fn.holes;
        end
        if (fn.print === 1'b1) begin
            n_pr++;
        end
        if (fn.advance === 1'b1) begin
            n_ad++;
        end
    end
    task automatic wrap_up();
        $display("checks=%0d failures=%0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // 0 frame received, 1 far end idle, 2 function idle
    task automatic wt(input int k);
        int n;
        n = 0;
        @(negedge clk);
        while (!(k == 0 ? rx.valid === 1'b1 : k == 1 ? mbusy === 1'b0 : busy === 1'b0)) begin
            n++;
            if (n > 20000) begin
                failures++;
                $display("[ERR] t=%0t got=%h exp=%h", $time, n, k);
                wrap_up();
            end
            @(negedge clk);
        end
    endtask
    task automatic send(input logic [7:0] c, input logic b);
        wt(1);
        code = c;
        bad = b;
        go = 1'b1;
        @(negedge clk);
        go = 1'b0;
        wt(0);
    endtask
    task automatic sc_back_to_back();
        int p;
        int a;
        p = n_pu;
        a = n_ad;
        send(8'hD5, 1'b0);
        chk(rx.code, 8'hD5);
        chk(8'(rx.frame_err), 8'h00);
        send(8'hAA, 1'b0);
        chk(rx.code, 8'hAA);
        wt(2);
        chk(holes, 8'hAA);
        chk(8'(n_pu - p), 8'h02);
        chk(8'(n_ad - a), 8'h02);
    endtask
    task automatic sc_parity();
        par = 1'b1;
        send(8'h41, 1'b0);
        chk(8'(rx.parity_err), 8'h00);
        send(8'hC1, 1'b0);
        chk(8'(rx.parity_err), 8'h01);
        par = 1'b0;
    endtask
    task automatic sc_frame_err();
        send(8'hFF, 1'b1);
        chk(8'(rx.frame_err), 8'h01);
        send(8'h80, 1'b0);
        chk(rx.code, 8'h80);
    endtask
    task automatic sc_feed();
        int p;
        int q;
        wt(2);
        p = n_pu;
        q = n_pr;
        feed = 1'b1;
        @(negedge clk);
        feed = 1'b0;
        repeat (3) @(negedge clk);
        wt(2);
        chk(8'(n_pu - p), 8'h01);
        chk(holes, 8'h00);
        chk(8'(n_pr - q), 8'h00);
    endtask
    task automatic sc_mono();
        int q;
        mono = 1'b1;
        q = n_pr;
        send(8'h8D, 1'b0);
        wt(2);
        chk(8'(n_pr - q), 8'h00);
        send(8'hC1, 1'b0);
        wt(2);
        chk(8'(n_pr - q), 8'h01);
        mono = 1'b0;
    endtask
    task automatic sc_offset();
        // A 100-cycle spacing pulse: refused at centre, taken at an early sample point
        ofs = 8'sh00;
        glitch = 1'b1;
        repeat (100) @(negedge clk);
        glitch = 1'b0;
        repeat (200) @(negedge clk);
        chk(8'(rest), 8'h01);
        ofs = -8'sh64;
        glitch = 1'b1;
        repeat (100) @(negedge clk);
        glitch = 1'b0;
        repeat (200) @(negedge clk);
        chk(8'(rest), 8'h00);
        wt(0);
        chk(rx.code, 8'hFF);
        send(8'hB3, 1'b0);
        chk(rx.code, 8'hB3);
        ofs = 8'sh00;
        send(8'h9C, 1'b0);
        chk(rx.code, 8'h9C);
    endtask
    initial begin
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        sc_back_to_back();
        sc_parity();
        sc_frame_err();
        sc_feed();
        sc_mono();
        sc_offset();
        wrap_up();
    end
endmodule // ssr_receiver_tb
`default_nettype wire
